// ### rtl/iscen_top.sv
// Interrupt enable, sticky status with write-one clear except bit 3, interrupt pin, channel enables.
// Assumes event inputs and register requests are synchronous to sys_clk.
//
// What this block does
// R1: Enabled parity error sets status bit 7 and requests an interrupt.
// R2: Enabled self-test completion sets status bit 6 and requests an interrupt.
// R3: Enabled rise of parameter update flag sets status bit 5.
// R4: Enabled fall of parameter update flag sets status bit 4.
// R5: Enabled handoff lock acquisition sets status bit 3.
// R6: Enabled handoff lock loss sets status bit 2.
// R7: Enabled overflow into sixteen-times interpolator sets status bit 1.
// R8: Any interrupt request drives the interrupt pin low.
// R9: Status bit 7 marks parity errors; writing one clears it.
// R10: Status bit 6 marks self-test end; writing one clears it.
// R11: Status bit 5 marks parameter update set; writing one clears it.
// R12: Status bit 4 marks parameter update cleared; writing one clears it.
// R13: Status bit 3 reads one while handoff locked; writes do not clear it.
// R14: Status bit 2 marks lock lost; writing one clears it.
// R15: Status bit 1 marks saturation overflow; writing one clears it.
// R16: Channel enable bits 3:0 enable channels zero to three; 7:4 reserved.
// R17: All zeros disables every channel, all ones enables all four.
// R18: Writing one to status bit 1 also zeroes the overflow sample counter.
// R19: Pin stays low while any enabled status bit is set.
`include "iscen_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module iscen_top #(
	parameter int CHANNELS = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire iscen_pkg::iscen_req_s reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire iscen_pkg::iscen_evt_s evt,
	output logic irq_n,
	output logic [CHANNELS-1:0] channel_on_bits,
	output logic [7:0] overflow_sample_count
);

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic iscen_hit(input logic strobe, input logic [7:0] addr,
		input logic [7:0] target);
		iscen_hit = strobe && (addr == target);
	endfunction : iscen_hit

	logic wr_enable;
	logic wr_status;
	logic wr_chan;
	assign wr_enable = iscen_hit(reg_req.wr, reg_req.addr, `ISCEN_ADDR_IRQ_ENABLE);
	assign wr_status = iscen_hit(reg_req.wr, reg_req.addr, `ISCEN_ADDR_IRQ_STATUS);
	assign wr_chan = iscen_hit(reg_req.wr, reg_req.addr, `ISCEN_ADDR_CHAN_ENABLE);

	// ****************************************
	// Edge detection of level sources
	// ****************************************
	logic param_prev_reg;
	logic lock_prev_reg;
	logic param_update_raised;
	logic param_update_dropped;
	logic handoff_locked_flag;
	logic handoff_unlocked_flag;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			param_prev_reg <= 1'b0;
			lock_prev_reg <= 1'b0;
		end else if (clk_en) begin
			param_prev_reg <= evt.param_update_level;
			lock_prev_reg <= evt.handoff_lock_level;
		end
	end

	// Levels low at reset, so a source already high then counts as a rise
	assign param_update_raised = evt.param_update_level && !param_prev_reg;
	assign param_update_dropped = !evt.param_update_level && param_prev_reg;
	assign handoff_locked_flag = evt.handoff_lock_level && !lock_prev_reg;
	assign handoff_unlocked_flag = !evt.handoff_lock_level && lock_prev_reg;

	// ****************************************
	// Interrupt enable register
	// ****************************************
	logic [7:0] irq_enable_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_enable_reg <= `ISCEN_IRQ_ENABLE_RST;
		end else if (clk_en && wr_enable) begin
			irq_enable_reg <= reg_req.wdata & `ISCEN_IRQ_MASK;
		end
	end

	// ****************************************
	// Sticky status bits
	// ****************************************
	logic [7:0] event_vec;
	logic [7:0] set_vec;
	logic [7:0] clr_vec;
	logic [7:0] irq_status_reg;

	always_comb begin
		event_vec = 8'h00;
		event_vec[`ISCEN_BIT_PARITY] = evt.parity_fault_flag;
		event_vec[`ISCEN_BIT_SELFTEST] = evt.selftest_complete_flag;
		event_vec[`ISCEN_BIT_PARAM_SET] = param_update_raised;
		event_vec[`ISCEN_BIT_PARAM_CLR] = param_update_dropped;
		event_vec[`ISCEN_BIT_LOCK_ACQ] = handoff_locked_flag;
		event_vec[`ISCEN_BIT_LOCK_LOST] = handoff_unlocked_flag;
		event_vec[`ISCEN_BIT_OVERFLOW] = evt.overflow_fault_flag;
	end

	assign set_vec = event_vec & irq_enable_reg; // R1 R2 R3 R4 R5 R6 R7

	always_comb begin
		clr_vec = wr_status ? (reg_req.wdata & `ISCEN_IRQ_MASK) : 8'h00; // R9 R10 R11 R12 R14 R15
		// Lock bit follows the handoff, so only lock loss drops it
		clr_vec[`ISCEN_BIT_LOCK_ACQ] = handoff_unlocked_flag; // R13
	end

	assign irq_status_reg[0] = 1'b0;

	localparam logic [7:0] STATUS_RST = `ISCEN_IRQ_STATUS_RST;

	genvar gi;
	generate
		for (gi = `ISCEN_BIT_LOW; gi <= `ISCEN_BIT_HIGH; gi++) begin : g_status
			logic bit_reg;
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					bit_reg <= STATUS_RST[gi];
				end else if (clk_en) begin
					// Set wins over a clear in the same cycle
					bit_reg <= set_vec[gi] | (bit_reg & ~clr_vec[gi]); // R9 R10 R11 R12 R14 R15
				end
			end
			assign irq_status_reg[gi] = bit_reg;
		end
	endgenerate

	// ****************************************
	// Interrupt pin
	// ****************************************
	// Combinational from flops only, so no glitch from the request port
	assign irq_n = ~|(irq_status_reg & irq_enable_reg); // R8 R19

	// ****************************************
	// Channel enable register
	// ****************************************
	logic [7:0] chan_enable_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			chan_enable_reg <= `ISCEN_CHAN_ENABLE_RST;
		end else if (clk_en && wr_chan) begin
			chan_enable_reg <= reg_req.wdata & `ISCEN_CHAN_MASK; // R16
		end
	end

	assign channel_on_bits = chan_enable_reg[CHANNELS-1:0]; // R16 R17

	// ****************************************
	// Overflow sample counter
	// ****************************************
	logic [7:0] ovf_count_reg;
	logic ovf_clear;
	assign ovf_clear = wr_status && reg_req.wdata[`ISCEN_BIT_OVERFLOW];

	// Saturates rather than wraps, so a large count never reads small
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ovf_count_reg <= `ISCEN_OVF_COUNT_RST;
		end else if (clk_en) begin
			if (ovf_clear) begin
				ovf_count_reg <= evt.overflow_fault_flag ? 8'h01 : `ISCEN_OVF_COUNT_RST; // R18
			end else if (evt.overflow_fault_flag && ovf_count_reg != `ISCEN_OVF_COUNT_MAX) begin
				ovf_count_reg <= ovf_count_reg + 8'h01;
			end
		end
	end

	assign overflow_sample_count = ovf_count_reg;

	// ****************************************
	// Read path
	// ****************************************
	logic [7:0] rdata_reg;
	logic rvalid_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_reg <= `ISCEN_RDATA_RST;
			rvalid_reg <= 1'b0;
		end else if (clk_en) begin
			rvalid_reg <= reg_req.rd;
			if (reg_req.rd) begin
				case (reg_req.addr)
					`ISCEN_ADDR_OVF_COUNT: rdata_reg <= ovf_count_reg;
					`ISCEN_ADDR_IRQ_ENABLE: rdata_reg <= irq_enable_reg;
					`ISCEN_ADDR_IRQ_STATUS: rdata_reg <= irq_status_reg;
					`ISCEN_ADDR_CHAN_ENABLE: rdata_reg <= chan_enable_reg;
					default: rdata_reg <= `ISCEN_RDATA_RST;
				endcase
			end
		end
	end

	assign reg_rdata = rdata_reg;
	assign reg_rvalid = rvalid_reg;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_parity_sets: assert property ( // R1
		clk_en && evt.parity_fault_flag && irq_enable_reg[`ISCEN_BIT_PARITY]
		|=> irq_status_reg[`ISCEN_BIT_PARITY] && !irq_n)
		else $error("parity event did not set status");

	a_selftest_sets: assert property ( // R2
		clk_en && evt.selftest_complete_flag && irq_enable_reg[`ISCEN_BIT_SELFTEST]
		|=> irq_status_reg[`ISCEN_BIT_SELFTEST])
		else $error("self-test event did not set status");

	a_param_rise: assert property ( // R3
		clk_en && !param_prev_reg && evt.param_update_level
		&& irq_enable_reg[`ISCEN_BIT_PARAM_SET]
		|=> irq_status_reg[`ISCEN_BIT_PARAM_SET])
		else $error("parameter set edge missed");

	a_param_fall: assert property ( // R4
		clk_en && param_update_dropped && irq_enable_reg[`ISCEN_BIT_PARAM_CLR]
		|=> irq_status_reg[`ISCEN_BIT_PARAM_CLR])
		else $error("parameter clear edge missed");

	a_lock_acq: assert property ( // R5
		clk_en && handoff_locked_flag && irq_enable_reg[`ISCEN_BIT_LOCK_ACQ]
		|=> irq_status_reg[`ISCEN_BIT_LOCK_ACQ])
		else $error("lock acquisition missed");

	a_lock_lost: assert property ( // R6
		clk_en && handoff_unlocked_flag && irq_enable_reg[`ISCEN_BIT_LOCK_LOST]
		|=> irq_status_reg[`ISCEN_BIT_LOCK_LOST] && !irq_status_reg[`ISCEN_BIT_LOCK_ACQ])
		else $error("lock loss missed");

	a_ovf_sets: assert property ( // R7
		clk_en && evt.overflow_fault_flag && irq_enable_reg[`ISCEN_BIT_OVERFLOW]
		|=> irq_status_reg[`ISCEN_BIT_OVERFLOW])
		else $error("overflow event did not set status");

	a_masked_quiet: assert property ( // R1
		clk_en && !irq_enable_reg[`ISCEN_BIT_PARITY] && !irq_status_reg[`ISCEN_BIT_PARITY]
		&& !(wr_enable && reg_req.wdata[`ISCEN_BIT_PARITY])
		|=> !irq_status_reg[`ISCEN_BIT_PARITY])
		else $error("disabled parity event set status");

	a_pin_low: assert property ( // R8
		(irq_status_reg & irq_enable_reg) != 8'h00 |-> !irq_n)
		else $error("pin high with pending request");

	a_pin_release: assert property ( // R19
		irq_status_reg == 8'h00 |-> irq_n)
		else $error("pin low with no status");

	a_w1c_parity: assert property ( // R9
		clk_en && wr_status && reg_req.wdata[`ISCEN_BIT_PARITY] && !evt.parity_fault_flag
		|=> !irq_status_reg[`ISCEN_BIT_PARITY])
		else $error("write one did not clear parity status");

	a_w1c_selftest: assert property ( // R10
		clk_en && wr_status && reg_req.wdata[`ISCEN_BIT_SELFTEST]
		&& !set_vec[`ISCEN_BIT_SELFTEST]
		|=> !irq_status_reg[`ISCEN_BIT_SELFTEST])
		else $error("write one did not clear self-test status");

	a_status_hold: assert property ( // R11
		clk_en && irq_status_reg[`ISCEN_BIT_PARAM_SET]
		&& !(wr_status && reg_req.wdata[`ISCEN_BIT_PARAM_SET])
		|=> irq_status_reg[`ISCEN_BIT_PARAM_SET])
		else $error("parameter set status dropped on its own");

	a_w1c_param_clr: assert property ( // R12
		clk_en && wr_status && reg_req.wdata[`ISCEN_BIT_PARAM_CLR]
		&& !set_vec[`ISCEN_BIT_PARAM_CLR]
		|=> !irq_status_reg[`ISCEN_BIT_PARAM_CLR])
		else $error("write one did not clear parameter clear status");

	a_w1c_ovf: assert property ( // R15
		clk_en && wr_status && reg_req.wdata[`ISCEN_BIT_OVERFLOW]
		&& !set_vec[`ISCEN_BIT_OVERFLOW]
		|=> !irq_status_reg[`ISCEN_BIT_OVERFLOW])
		else $error("write one did not clear overflow status");

	a_set_wins: assert property ( // R15
		clk_en && wr_status && reg_req.wdata[`ISCEN_BIT_OVERFLOW]
		&& set_vec[`ISCEN_BIT_OVERFLOW]
		|=> irq_status_reg[`ISCEN_BIT_OVERFLOW] && ovf_count_reg == 8'h01)
		else $error("event lost against clear");

	a_lock_no_w1c: assert property ( // R13
		clk_en && irq_status_reg[`ISCEN_BIT_LOCK_ACQ] && evt.handoff_lock_level
		|=> irq_status_reg[`ISCEN_BIT_LOCK_ACQ])
		else $error("lock status cleared while locked");

	a_w1c_lost: assert property ( // R14
		clk_en && wr_status && reg_req.wdata[`ISCEN_BIT_LOCK_LOST]
		&& !set_vec[`ISCEN_BIT_LOCK_LOST]
		|=> !irq_status_reg[`ISCEN_BIT_LOCK_LOST])
		else $error("write one did not clear lock loss status");

	a_chan_write: assert property ( // R16
		clk_en && wr_chan |=> chan_enable_reg == ($past(reg_req.wdata) & 8'h0f)
		&& channel_on_bits == $past(reg_req.wdata[3:0]))
		else $error("channel enable write not applied");

	a_chan_hold: assert property ( // R17
		!(clk_en && wr_chan) |=> $stable(channel_on_bits))
		else $error("channel enables changed without a write");

	a_chan_reserved: assert property ( // R16
		chan_enable_reg[7:4] == 4'h0)
		else $error("reserved channel enable bits set");

	a_ovf_clear: assert property ( // R18
		clk_en && ovf_clear && !evt.overflow_fault_flag
		|=> ovf_count_reg == 8'h00 ##1 (ovf_count_reg <= 8'h01))
		else $error("overflow counter not zeroed");

	c_irq_cycle: cover property (
		irq_n ##1 !irq_n ##[1:20] irq_n);
	c_set_clear_same: cover property (
		clk_en && wr_status && (set_vec & reg_req.wdata) != 8'h00);
	c_all_channels: cover property (
		channel_on_bits == 4'hf ##[1:20] channel_on_bits == 4'h0);
	c_lock_cycle: cover property (
		handoff_locked_flag ##[1:50] handoff_unlocked_flag);

endmodule : iscen_top
`default_nettype wire

// ### pkg/iscen_defs.svh
// Addresses, bit positions and reset values of the interrupt and channel enable block.
// Assumes an 8-bit register port that presents decoded serial-port accesses.
`ifndef ISCEN_DEFS_SVH
`define ISCEN_DEFS_SVH

// ****************************************
// Register addresses
// ****************************************
`define ISCEN_ADDR_OVF_COUNT 8'h01
`define ISCEN_ADDR_IRQ_ENABLE 8'h03
`define ISCEN_ADDR_IRQ_STATUS 8'h04
`define ISCEN_ADDR_CHAN_ENABLE 8'h05

// ****************************************
// Status and enable bit positions
// ****************************************
`define ISCEN_BIT_PARITY 7
`define ISCEN_BIT_SELFTEST 6
`define ISCEN_BIT_PARAM_SET 5
`define ISCEN_BIT_PARAM_CLR 4
`define ISCEN_BIT_LOCK_ACQ 3
`define ISCEN_BIT_LOCK_LOST 2
`define ISCEN_BIT_OVERFLOW 1
`define ISCEN_BIT_LOW 1
`define ISCEN_BIT_HIGH 7

// ****************************************
// Masks and reset values
// ****************************************
`define ISCEN_IRQ_MASK 8'hfe
`define ISCEN_CHAN_MASK 8'h0f
`define ISCEN_IRQ_ENABLE_RST 8'h00
`define ISCEN_IRQ_STATUS_RST 8'h00
`define ISCEN_CHAN_ENABLE_RST 8'h00
`define ISCEN_OVF_COUNT_RST 8'h00
`define ISCEN_OVF_COUNT_MAX 8'hff
`define ISCEN_RDATA_RST 8'h00

`endif

// ### pkg/iscen_pkg.sv
// Types shared by the interrupt and channel enable block.
// Assumes the register port and event sources sit in the same clock domain.
`default_nettype none
package iscen_pkg;

	// ****************************************
	// Register access request
	// ****************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} iscen_req_s;

	// ****************************************
	// Event sources
	// ****************************************
	typedef struct packed {
		logic parity_fault_flag;
		logic selftest_complete_flag;
		logic param_update_level;
		logic handoff_lock_level;
		logic overflow_fault_flag;
	} iscen_evt_s;

endpackage : iscen_pkg
`default_nettype wire

// ### dv/iscen_host_model.sv
// Host processor model: drives register accesses and collects read data.
// Assumes the register port of iscen_top, strobes one cycle wide.
`timescale 1ns/1ns
`default_nettype none

module iscen_host_model (
	input wire logic sys_clk,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	output var iscen_pkg::iscen_req_s req
);
	initial begin
		req = '0;
	end

	// ****************************************
	// Access tasks, changed at the falling edge
	// ****************************************
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge sys_clk);
		req.wr = 1'b0;
		// Released data never keeps the last value
		req.wdata = ~d;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(negedge sys_clk);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge sys_clk);
		req.rd = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (reg_rvalid === 1'b1) begin
				ok = 1'b1;
				d = reg_rdata;
				break;
			end
			@(negedge sys_clk);
		end
	endtask : read_reg
endmodule : iscen_host_model
`default_nettype wire

// ### dv/irq_status_and_channel_enable_tb_top.sv
// Self-checking bench for iscen_top driven through the host model.
// Assumes inputs change at the falling edge of a 125 MHz clock.
`timescale 1ns/1ns
`default_nettype none

module irq_status_and_channel_enable_tb_top;
	localparam logic [4:0] EV_PAR = 5'h10;
	localparam logic [4:0] EV_ST = 5'h08;
	localparam logic [4:0] EV_PRM = 5'h04;
	localparam logic [4:0] EV_LCK = 5'h02;
	localparam logic [4:0] EV_OVF = 5'h01;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	iscen_pkg::iscen_req_s reg_req;
	iscen_pkg::iscen_evt_s evt = '0;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic irq_n;
	logic [3:0] channel_on_bits;
	logic [7:0] overflow_sample_count;
	int bad_count = 0;
	int total_checks = 0;
	logic [7:0] ch_in [4] = '{8'h00, 8'h01, 8'h0e, 8'hff};
	logic [7:0] ch_out [4] = '{8'h00, 8'h01, 8'h0e, 8'h0f};
	int bit_pos [3] = '{7, 6, 1};
	logic [4:0] bit_ev [3] = '{EV_PAR, EV_ST, EV_OVF};

	always #4 sys_clk = ~sys_clk;

	iscen_top #(.CHANNELS(4)) DUT (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.reg_req(reg_req),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.evt(evt),
		.irq_n(irq_n),
		.channel_on_bits(channel_on_bits),
		.overflow_sample_count(overflow_sample_count)
	);

	iscen_host_model host (
		.sys_clk(sys_clk),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.req(reg_req)
	);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic conclude;
		if (bad_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		logic ok;
		host.read_reg(a, d, ok);
		// A missing answer ends the run at once
		if (ok !== 1'b1) begin
			check("read answer", 8'h00, 8'h01);
			conclude();
		end else begin
			check(what, d, exp);
		end
	endtask : rd

	task automatic set_evt(input logic [4:0] m, input logic v);
		@(negedge sys_clk);
		evt = v ? iscen_pkg::iscen_evt_s'(evt | m) : iscen_pkg::iscen_evt_s'(evt & ~m);
	endtask : set_evt

	task automatic pin(input logic exp);
		check("irq_n", {7'h00, irq_n}, {7'h00, exp});
	endtask : pin

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		pin(1'b1);
		rd(8'h03, 8'h00, "enable reset");
		rd(8'h04, 8'h00, "status reset");
		rd(8'h05, 8'h00, "channel reset");
		rd(8'h02, 8'h00, "unmapped read");
		for (int i = 0; i < 4; i++) begin
			host.write_reg(8'h05, ch_in[i]);
			rd(8'h05, ch_out[i], "channel readback");
			check("channel pins", {4'h0, channel_on_bits}, ch_out[i]);
		end
		host.write_reg(8'h03, 8'hff);
		rd(8'h03, 8'hfe, "enable readback");
		for (int i = 0; i < 3; i++) begin
			host.write_reg(8'h03, 8'h01 << bit_pos[i]);
			set_evt(bit_ev[i], 1'b1);
			set_evt(bit_ev[i], 1'b0);
			pin(1'b0);
			rd(8'h04, 8'h01 << bit_pos[i], "pulse status");
			host.write_reg(8'h04, 8'h01 << bit_pos[i]);
			pin(1'b1);
			rd(8'h04, 8'h00, "pulse cleared");
			host.write_reg(8'h03, 8'h00);
			set_evt(bit_ev[i], 1'b1);
			set_evt(bit_ev[i], 1'b0);
			rd(8'h04, 8'h00, "disabled dropped");
		end
		// Counter runs regardless of the enable
		host.write_reg(8'h04, 8'h02);
		check("count cleared", overflow_sample_count, 8'h00);
		set_evt(EV_OVF, 1'b1);
		repeat (2) @(negedge sys_clk);
		set_evt(EV_OVF, 1'b0);
		check("count three", overflow_sample_count, 8'h03);
		rd(8'h01, 8'h03, "count read");
		pin(1'b1);
		host.write_reg(8'h04, 8'h02);
		rd(8'h01, 8'h00, "count after clear");
		host.write_reg(8'h03, 8'h30);
		set_evt(EV_PRM, 1'b1);
		rd(8'h04, 8'h20, "param set");
		set_evt(EV_PRM, 1'b0);
		rd(8'h04, 8'h30, "param cleared");
		pin(1'b0);
		host.write_reg(8'h04, 8'h30);
		rd(8'h04, 8'h00, "param wipe");
		host.write_reg(8'h03, 8'h0c);
		set_evt(EV_LCK, 1'b1);
		rd(8'h04, 8'h08, "lock acquired");
		host.write_reg(8'h04, 8'h08);
		rd(8'h04, 8'h08, "lock not cleared");
		set_evt(EV_LCK, 1'b0);
		rd(8'h04, 8'h04, "lock lost");
		pin(1'b0);
		host.write_reg(8'h04, 8'h04);
		rd(8'h04, 8'h00, "lost cleared");
		// Pin follows enabled bits only; status is kept
		host.write_reg(8'h03, 8'h80);
		set_evt(EV_PAR, 1'b1);
		set_evt(EV_PAR, 1'b0);
		host.write_reg(8'h03, 8'h00);
		pin(1'b1);
		rd(8'h04, 8'h80, "status kept");
		host.write_reg(8'h03, 8'h80);
		pin(1'b0);
		host.write_reg(8'h04, 8'h80);
		pin(1'b1);
		@(negedge sys_clk);
		clk_en = 1'b0;
		host.write_reg(8'h05, 8'h00);
		@(negedge sys_clk);
		clk_en = 1'b1;
		rd(8'h05, 8'h0f, "frozen write");
		conclude();
	end
endmodule : irq_status_and_channel_enable_tb_top
`default_nettype wire
